// ==== hw/bma_device.sv ====
// Bus arbiter device end: four-master arbitration, pin release, register write timing
// Behaviour
// (R1) Fixed rank: external, refresh, DMA, CPU.
// (R2) Grant only highest; owner keeps bus while acknowledged.
// (R3) Evaluate always; switch only at release points.
// (R4) CPU yields at cycle boundary, not mid-word.
// (R5) CPU internal work or sleep: hand over immediately.
// (R6) DMA yields only after whole byte/word transfer.
// (R7) Refresh requests, releases at refresh end.
// (R8) External requests ignored unless release enable set.
// (R9) External master requests low, keeps until high.
// (R10) Released: float bus pins, drive acknowledge low.
// (R11) Sample request pin every rising clock edge.
// (R12) Two high samples end the release.
// (R13) At least three states from request to release.
// (R14) Master holds request until acknowledge low.
// (R15) Master holds request high three states minimum.
// (R16) Software clears release enable before standby.
// (R17) Width/state/wait writes apply next bus cycle.
// (R18) Chip-select function switches at write state three.
// (R19) Upper address function switches at write state three.
// (R20) CPU owns bus by default, no gap.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "bma_cfg.svh"
module bma_device (
   input wire logic mclk_i,
   input wire logic srst_i,
   // Avalon-MM slave, word index address
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Internal masters
   input wire logic cpu_cycle_boundary_i,
   input wire logic cpu_internal_i,
   input wire logic dma_req_i,
   input wire logic dma_xfer_done_i,
   input wire logic refresh_req_i,
   input wire logic refresh_done_i,
   // Values the internal bus engine wants on the pins
   input wire logic [23:0] bus_addr_i,
   input wire logic [15:0] bus_data_i,
   input wire logic bus_data_drive_i,
   input wire logic [3:0] bus_strobe_n_i,
   input wire logic [7:0] bus_cs_n_i,
   // Grants
   output logic cpu_grant_o,
   output logic dma_grant_o,
   output logic refresh_grant_o,
   output logic ext_grant_o,
   // Settings in force
   output logic [7:0] bus_width_o,
   output logic [7:0] access_state_o,
   output logic [15:0] wait_control_o,
   output logic [3:0] addr_hi_enable_o,
   bma_ext_if.device pins
);
   // --------------------------------------------------
   // Registers
   // --------------------------------------------------
   logic [7:0] bus_release_control_reg; // Release enable and upper address function
   logic [7:0] bus_width_control_reg; // Staged values
   logic [7:0] access_state_control_reg;
   logic [7:0] wait_control_reg_hi;
   logic [7:0] wait_control_reg_lo;
   logic [7:0] chip_select_control_reg; // Per chip select output enable
   logic [1:0] acc_state_reg; // Access state counter, 0 = idle
   logic acc_state_t3; // Third state of an access
   logic bus_release_enable;
   assign bus_release_enable = bus_release_control_reg[`BMA_REL_EN_BIT];
   assign acc_state_t3 = (acc_state_reg == `BMA_ACC_STATES);
   // --------------------------------------------------
   // Bus access state sequence
   // --------------------------------------------------
   // Every access runs T1, T2, T3; waitrequest drops in T3
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         acc_state_reg <= 2'd0;
      end else if (acc_state_t3) begin
         acc_state_reg <= 2'd0;
      end else if (avs_read_i || avs_write_i) begin
         acc_state_reg <= acc_state_reg + 2'd1;
      end
   end
   // Waitrequest from a flop: low only for the T3 cycle, high while idle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && (acc_state_reg == (`BMA_ACC_STATES - 2'd1)));
      end
   end
   // Register writes land in T3; pin-function registers act from here on
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         bus_release_control_reg <= `BMA_REL_CTL_RST;
         bus_width_control_reg <= `BMA_ABW_RST;
         access_state_control_reg <= `BMA_AST_RST;
         wait_control_reg_hi <= `BMA_WC_RST;
         wait_control_reg_lo <= `BMA_WC_RST;
         chip_select_control_reg <= `BMA_CSC_RST;
      end else if (avs_write_i && acc_state_t3) begin
         if (avs_address_i == `BMA_IDX_REL_CTL) begin
            bus_release_control_reg <= avs_writedata_i[7:0]; // R19
         end else if (avs_address_i == `BMA_IDX_ABW) begin
            bus_width_control_reg <= avs_writedata_i[7:0];
         end else if (avs_address_i == `BMA_IDX_AST) begin
            access_state_control_reg <= avs_writedata_i[7:0];
         end else if (avs_address_i == `BMA_IDX_WCH) begin
            wait_control_reg_hi <= avs_writedata_i[7:0];
         end else if (avs_address_i == `BMA_IDX_WCL) begin
            wait_control_reg_lo <= avs_writedata_i[7:0];
         end else if (avs_address_i == `BMA_IDX_CSC) begin
            chip_select_control_reg <= avs_writedata_i[7:0]; // R18
         end
      end
   end
   // Staged settings move into force only at the next cycle boundary
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         bus_width_o <= `BMA_ABW_RST;
         access_state_o <= `BMA_AST_RST;
         wait_control_o <= {`BMA_WC_RST, `BMA_WC_RST};
      end else if (cpu_cycle_boundary_i) begin
         bus_width_o <= bus_width_control_reg; // R17
         access_state_o <= access_state_control_reg; // R17
         wait_control_o <= {wait_control_reg_hi, wait_control_reg_lo}; // R17
      end
   end
   // --------------------------------------------------
   // External request sampling
   // --------------------------------------------------
   logic [1:0] req_low_cnt_reg; // Consecutive low samples, saturating
   logic [1:0] req_high_cnt_reg; // Consecutive high samples, saturating
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         req_low_cnt_reg <= 2'd0;
         req_high_cnt_reg <= 2'd0;
      end else if (!pins.ext_bus_request_n) begin
         req_high_cnt_reg <= 2'd0; // R11
         if (req_low_cnt_reg != 2'd3) begin
            req_low_cnt_reg <= req_low_cnt_reg + 2'd1;
         end
      end else begin
         req_low_cnt_reg <= 2'd0;
         if (req_high_cnt_reg != 2'd3) begin
            req_high_cnt_reg <= req_high_cnt_reg + 2'd1;
         end
      end
   end
   // Two low samples plus the owner flop give three states before release
   logic ext_pending; // R13
   assign ext_pending = bus_release_enable && (req_low_cnt_reg >= `BMA_REQ_LOW_SAMPLES); // R8
   // --------------------------------------------------
   // Arbitration
   // --------------------------------------------------
   bma_pkg::bma_owner_t owner_reg;
   bma_pkg::bma_owner_t owner_next;
   logic release_ok; // Current owner at a release point
   logic [7:0] status_word;
   // Release point of each owner
   always_comb begin
      case (owner_reg)
         bma_pkg::BMA_OWN_CPU: release_ok = cpu_cycle_boundary_i || cpu_internal_i; // R4 R5
         bma_pkg::BMA_OWN_DMA: release_ok = dma_xfer_done_i || !dma_req_i; // R6
         bma_pkg::BMA_OWN_REF: release_ok = refresh_done_i || !refresh_req_i; // R7
         default: release_ok = (req_high_cnt_reg >= `BMA_REL_HIGH_SAMPLES); // R9 R12
      endcase
   end
   // Fixed priority pick, CPU as fallback
   always_comb begin
      owner_next = owner_reg; // R3
      if (release_ok) begin
         if (ext_pending) begin
            owner_next = bma_pkg::BMA_OWN_EXT; // R1 R2
         end else if (refresh_req_i && !refresh_done_i) begin
            owner_next = bma_pkg::BMA_OWN_REF; // R1
         end else if (dma_req_i) begin
            owner_next = bma_pkg::BMA_OWN_DMA; // R1
         end else begin
            owner_next = bma_pkg::BMA_OWN_CPU; // R20
         end
      end
   end
   // Owner and grants; outputs registered from the next owner
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         owner_reg <= bma_pkg::BMA_OWN_CPU;
         cpu_grant_o <= 1'b1;
         dma_grant_o <= 1'b0;
         refresh_grant_o <= 1'b0;
         ext_grant_o <= 1'b0;
      end else begin
         owner_reg <= owner_next;
         cpu_grant_o <= (owner_next == bma_pkg::BMA_OWN_CPU); // R2
         dma_grant_o <= (owner_next == bma_pkg::BMA_OWN_DMA);
         refresh_grant_o <= (owner_next == bma_pkg::BMA_OWN_REF);
         ext_grant_o <= (owner_next == bma_pkg::BMA_OWN_EXT);
      end
   end
   // --------------------------------------------------
   // Pins
   // --------------------------------------------------
   // Pins float and acknowledge goes low while the external master owns the bus
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         pins.bus_ack_n <= 1'b1;
         pins.dev_addr <= 24'hFF_FFFF;
         pins.dev_addr_oe <= 1'b1;
         pins.dev_data <= 16'h0000;
         pins.dev_data_oe <= 1'b0;
         pins.dev_strobe_n <= 4'hF;
         pins.dev_strobe_oe <= 1'b1;
         pins.chip_select_n <= 8'hFF;
         pins.chip_select_oe <= 8'h00;
         addr_hi_enable_o <= 4'h0;
      end else begin
         pins.bus_ack_n <= (owner_next != bma_pkg::BMA_OWN_EXT); // R10
         pins.dev_addr <= bus_addr_i;
         pins.dev_addr_oe <= (owner_next != bma_pkg::BMA_OWN_EXT); // R10
         pins.dev_data <= bus_data_i;
         pins.dev_data_oe <= bus_data_drive_i && (owner_next != bma_pkg::BMA_OWN_EXT); // R10
         pins.dev_strobe_n <= bus_strobe_n_i;
         pins.dev_strobe_oe <= (owner_next != bma_pkg::BMA_OWN_EXT); // R10
         pins.chip_select_n <= bus_cs_n_i;
         // Chip-select function follows its control register, floated on release
         pins.chip_select_oe <= (owner_next == bma_pkg::BMA_OWN_EXT) ? 8'h00 : chip_select_control_reg; // R10 R18
         addr_hi_enable_o <= bus_release_control_reg[`BMA_AHI_MSB:`BMA_AHI_LSB]; // R19
      end
   end
   // --------------------------------------------------
   // Read path
   // --------------------------------------------------
   assign status_word = {4'h0, 1'b0, pins.bus_ack_n, owner_reg};
   // Read data registered, valid in T3; unmapped reads give zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i) begin
         if (avs_address_i == `BMA_IDX_REL_CTL) begin
            avs_readdata_o <= {24'h00_0000, bus_release_control_reg};
         end else if (avs_address_i == `BMA_IDX_ABW) begin
            avs_readdata_o <= {24'h00_0000, bus_width_control_reg};
         end else if (avs_address_i == `BMA_IDX_AST) begin
            avs_readdata_o <= {24'h00_0000, access_state_control_reg};
         end else if (avs_address_i == `BMA_IDX_WCH) begin
            avs_readdata_o <= {24'h00_0000, wait_control_reg_hi};
         end else if (avs_address_i == `BMA_IDX_WCL) begin
            avs_readdata_o <= {24'h00_0000, wait_control_reg_lo};
         end else if (avs_address_i == `BMA_IDX_CSC) begin
            avs_readdata_o <= {24'h00_0000, chip_select_control_reg};
         end else if (avs_address_i == `BMA_IDX_STAT) begin
            avs_readdata_o <= {24'h00_0000, status_word};
         end else begin
            avs_readdata_o <= 32'h0000_0000;
         end
      end
   end
endmodule : bma_device
`default_nettype wire

// ==== inc/bma_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the bus arbiter
`ifndef BMA_CFG_SVH
`define BMA_CFG_SVH
// --------------------------------------------------
// Register word indices (byte address = 4 * index)
// --------------------------------------------------
`define BMA_IDX_REL_CTL 3'h0
`define BMA_IDX_ABW 3'h1
`define BMA_IDX_AST 3'h2
`define BMA_IDX_WCH 3'h3
`define BMA_IDX_WCL 3'h4
`define BMA_IDX_CSC 3'h5
`define BMA_IDX_STAT 3'h6
// --------------------------------------------------
// Field positions and reset values
// --------------------------------------------------
`define BMA_REL_EN_BIT 0
`define BMA_AHI_LSB 4
`define BMA_AHI_MSB 7
`define BMA_REL_CTL_RST 8'h00
`define BMA_ABW_RST 8'hFF
`define BMA_AST_RST 8'hFF
`define BMA_WC_RST 8'hFF
`define BMA_CSC_RST 8'h00
// --------------------------------------------------
// Timing counts in clock states
// --------------------------------------------------
`define BMA_REQ_LOW_SAMPLES 2'd2
`define BMA_REL_HIGH_SAMPLES 2'd2
`define BMA_EXT_HIGH_HOLD 2'd3
`define BMA_ACC_STATES 2'd3
`endif

// ==== inc/bma_pkg.sv ====
// Types shared by both ends of the bus arbiter link
package bma_pkg;
   // Current bus owner
   typedef enum logic [1:0] {
      BMA_OWN_CPU = 2'b00,
      BMA_OWN_DMA = 2'b01,
      BMA_OWN_REF = 2'b10,
      BMA_OWN_EXT = 2'b11
   } bma_owner_t;
   // External master phases
   typedef enum logic [1:0] {
      BMA_EM_IDLE = 2'b00,
      BMA_EM_REQ = 2'b01,
      BMA_EM_OWN = 2'b10,
      BMA_EM_HOLD = 2'b11
   } bma_em_state_t;
endpackage : bma_pkg

// ==== inc/bma_ext_if.sv ====
// Pin-level link between the arbiter device and an external bus master
`timescale 1ns/1ps
`default_nettype none
interface bma_ext_if;
   logic ext_bus_request_n; // Request, active low, from external master
   logic bus_ack_n; // Acknowledge, active low, from device
   logic [23:0] dev_addr; // Device address drive
   logic dev_addr_oe;
   logic [15:0] dev_data; // Device data drive
   logic dev_data_oe;
   logic [3:0] dev_strobe_n; // address, read, high write, low write strobes
   logic dev_strobe_oe;
   logic [7:0] chip_select_n; // Chip selects
   logic [7:0] chip_select_oe;
   logic [23:0] ext_addr; // External master drives
   logic ext_addr_oe;
   logic [15:0] ext_data;
   logic ext_data_oe;
   logic [3:0] ext_strobe_n;
   logic ext_strobe_oe;
   // Resolved wire levels; undriven lines idle high as with pull-ups
   logic [23:0] addr;
   logic [15:0] data;
   logic [3:0] strobe_n;
   assign addr = dev_addr_oe ? dev_addr : (ext_addr_oe ? ext_addr : 24'hFF_FFFF);
   assign data = dev_data_oe ? dev_data : (ext_data_oe ? ext_data : 16'hFFFF);
   assign strobe_n = dev_strobe_oe ? dev_strobe_n : (ext_strobe_oe ? ext_strobe_n : 4'hF);
   modport device (
      input ext_bus_request_n, data, strobe_n,
      output bus_ack_n, dev_addr, dev_addr_oe, dev_data, dev_data_oe,
      output dev_strobe_n, dev_strobe_oe, chip_select_n, chip_select_oe
   );
   modport master (
      input bus_ack_n, addr, data, strobe_n,
      output ext_bus_request_n, ext_addr, ext_addr_oe, ext_data, ext_data_oe,
      output ext_strobe_n, ext_strobe_oe
   );
endinterface : bma_ext_if
`default_nettype wire

// ==== hw/bma_ext_master.sv ====
// External bus master end: request/acknowledge handshake and bus drive while granted
`timescale 1ns/1ps
`default_nettype none
`include "bma_cfg.svh"
module bma_ext_master (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic want_bus_i, // User wants the bus
   input wire logic [23:0] addr_i,
   input wire logic [15:0] data_i,
   input wire logic data_drive_i,
   input wire logic [3:0] strobe_n_i,
   output logic granted_o, // Bus held
   output logic [15:0] data_o, // Sampled data lines
   bma_ext_if.master pins
);
   // --------------------------------------------------
   // Handshake state
   // --------------------------------------------------
   bma_pkg::bma_em_state_t state_reg;
   logic [1:0] hold_cnt_reg; // High-hold counter after release
   // Request stays low until acknowledge; high held three states after release
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_reg <= bma_pkg::BMA_EM_IDLE;
         hold_cnt_reg <= 2'd0;
         pins.ext_bus_request_n <= 1'b1;
      end else begin
         case (state_reg)
            bma_pkg::BMA_EM_IDLE: begin
               if (want_bus_i) begin
                  pins.ext_bus_request_n <= 1'b0; // R9
                  state_reg <= bma_pkg::BMA_EM_REQ;
               end
            end
            bma_pkg::BMA_EM_REQ: begin
               // Request cannot be withdrawn before acknowledge
               if (!pins.bus_ack_n) begin
                  state_reg <= bma_pkg::BMA_EM_OWN; // R14
               end
            end
            bma_pkg::BMA_EM_OWN: begin
               if (!want_bus_i) begin
                  pins.ext_bus_request_n <= 1'b1; // R9
                  hold_cnt_reg <= 2'd1;
                  state_reg <= bma_pkg::BMA_EM_HOLD;
               end
            end
            default: begin
               // Stay high until counted and acknowledge returned
               if (hold_cnt_reg != `BMA_EXT_HIGH_HOLD) begin
                  hold_cnt_reg <= hold_cnt_reg + 2'd1; // R15
               end else if (pins.bus_ack_n) begin
                  state_reg <= bma_pkg::BMA_EM_IDLE;
               end
            end
         endcase
      end
   end
   // --------------------------------------------------
   // Bus drive
   // --------------------------------------------------
   // Drive only while acknowledged and still requesting
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         granted_o <= 1'b0;
         pins.ext_addr <= 24'h00_0000;
         pins.ext_addr_oe <= 1'b0;
         pins.ext_data <= 16'h0000;
         pins.ext_data_oe <= 1'b0;
         pins.ext_strobe_n <= 4'hF;
         pins.ext_strobe_oe <= 1'b0;
         data_o <= 16'h0000;
      end else begin
         granted_o <= (state_reg == bma_pkg::BMA_EM_OWN) && want_bus_i;
         pins.ext_addr <= addr_i;
         pins.ext_addr_oe <= (state_reg == bma_pkg::BMA_EM_OWN) && want_bus_i;
         pins.ext_data <= data_i;
         pins.ext_data_oe <= (state_reg == bma_pkg::BMA_EM_OWN) && want_bus_i && data_drive_i;
         pins.ext_strobe_n <= strobe_n_i;
         pins.ext_strobe_oe <= (state_reg == bma_pkg::BMA_EM_OWN) && want_bus_i;
         data_o <= pins.data;
      end
   end
endmodule : bma_ext_master
`default_nettype wire

// ==== tb/bma_checker_asserts.sv ====
// Concurrent checks on the request/acknowledge link between the two ends
`timescale 1ns/1ps
`default_nettype none
module bma_checker (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic ext_bus_request_n,
   input wire logic bus_ack_n,
   input wire logic dev_addr_oe,
   input wire logic dev_data_oe,
   input wire logic dev_strobe_oe,
   input wire logic [7:0] chip_select_oe,
   input wire logic ext_addr_oe
);
   // ------------------------------
   // Handshake and pin release
   // ------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // Released bus means every device pin floats
   a_ack_floats_pins: assert property (!bus_ack_n |-> !dev_addr_oe && !dev_data_oe && !dev_strobe_oe && chip_select_oe == 8'h00)
      else $error("device drives pins while bus released");
   // Grant only after two low samples of the request
   a_ack_after_low: assert property ($fell(bus_ack_n) |-> !$past(ext_bus_request_n, 1) && !$past(ext_bus_request_n, 2))
      else $error("acknowledge fell too early");
   // Owner keeps the bus while it still requests
   a_ack_holds: assert property (!bus_ack_n && !ext_bus_request_n |=> !bus_ack_n)
      else $error("acknowledge withdrawn under request");
   // Release ends only after two high samples
   a_end_needs_high: assert property ($rose(bus_ack_n) |-> $past(ext_bus_request_n, 1) && $past(ext_bus_request_n, 2))
      else $error("release ended without two high samples");
   // Two high samples end the release promptly
   a_end_prompt: assert property (!bus_ack_n && ext_bus_request_n && $past(ext_bus_request_n) |-> ##[1:2] bus_ack_n)
      else $error("release not ended after two high samples");
   // Device takes address and strobe pins back no later than one edge after release ends
   a_oe_back: assert property ($rose(bus_ack_n) |-> ##[0:1] dev_addr_oe && dev_strobe_oe)
      else $error("device pins not driven after release");
   // Master must not drop its request before the grant
   a_req_held: assert property ($rose(ext_bus_request_n) |-> !$past(bus_ack_n))
      else $error("request withdrawn before acknowledge");
   // Master keeps request high at least three states
   a_high_three: assert property ($rose(ext_bus_request_n) |-> ext_bus_request_n [*3])
      else $error("request high pulse too short");
   // Never both ends driving the address lines
   a_no_contention: assert property (ext_addr_oe |-> !dev_addr_oe)
      else $error("address line contention");
endmodule : bma_checker
`default_nettype wire

// ==== tb/bus_master_arbiter_with_release_tb.sv ====
// Self-checking bench joining device end and external master end
`timescale 1ns/1ps
`default_nettype none
module bus_master_arbiter_with_release_tb;
   // ------------------------------
   // Stimulus and observation
   // ------------------------------
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [2:0] avs_address_i = 3'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic boundary = 1'b1; // CPU at bus-cycle boundary
   logic internal = 1'b0;
   logic dma_req = 1'b0;
   logic dma_done = 1'b0;
   logic ref_req = 1'b0;
   logic ref_done = 1'b0;
   logic want = 1'b0; // External user wants the bus
   logic [23:0] bus_addr = 24'h00_0000;
   logic [23:0] m_addr = 24'h00_0000;
   logic [15:0] bus_data = 16'h0000;
   logic [7:0] bus_width, acc_state;
   logic [15:0] wait_ctl;
   logic [3:0] addr_hi;
   logic [15:0] m_data;
   logic [3:0] grants; // {ext, refresh, dma, cpu}
   logic m_granted; // External master holds the bus
   logic [7:0] w [0:5]; // Random register values
   logic [31:0] exp_q [$]; // Expected read data, oldest first
   int failures = 0;
   int checked = 0;
   always #5 mclk_i = ~mclk_i;
   bma_ext_if u_bma_ext_if ();
   bma_device u_bma_device (.mclk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_readdata_o, .avs_waitrequest_o, .cpu_cycle_boundary_i(boundary), .cpu_internal_i(internal),
      .dma_req_i(dma_req), .dma_xfer_done_i(dma_done), .refresh_req_i(ref_req), .refresh_done_i(ref_done),
      .bus_addr_i(bus_addr), .bus_data_i(bus_data), .bus_data_drive_i(1'b1), .bus_strobe_n_i(bus_addr[11:8]),
      .bus_cs_n_i(bus_addr[7:0]), .cpu_grant_o(grants[0]), .dma_grant_o(grants[1]),
      .refresh_grant_o(grants[2]), .ext_grant_o(grants[3]),
      .bus_width_o(bus_width), .access_state_o(acc_state), .wait_control_o(wait_ctl),
      .addr_hi_enable_o(addr_hi), .pins(u_bma_ext_if));
   bma_ext_master u_bma_ext_master (.mclk_i, .srst_i, .want_bus_i(want), .addr_i(m_addr), .data_i(m_addr[15:0]),
      .data_drive_i(1'b0), .strobe_n_i(4'hE), .granted_o(m_granted), .data_o(m_data), .pins(u_bma_ext_if));
   bma_checker u_bma_checker (.mclk_i(mclk_i), .srst_i(srst_i), .ext_bus_request_n(u_bma_ext_if.ext_bus_request_n),
      .bus_ack_n(u_bma_ext_if.bus_ack_n), .dev_addr_oe(u_bma_ext_if.dev_addr_oe),
      .dev_data_oe(u_bma_ext_if.dev_data_oe), .dev_strobe_oe(u_bma_ext_if.dev_strobe_oe),
      .chip_select_oe(u_bma_ext_if.chip_select_oe), .ext_addr_oe(u_bma_ext_if.ext_addr_oe));
   // Compare one value, count it, report a mismatch
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One Avalon access, held until waitrequest is sampled low
   task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h00_0000, d};
      avs_write_i <= wr;
      avs_read_i <= !wr;
      // Only the watchdog ends a wait that never completes
      do begin
         @(posedge mclk_i);
      end while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : acc
   // Read with the expected byte noted first
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      acc(1'b0, a, 8'h00);
   endtask : rd
   // Verdict and end of run
   task automatic final_report();
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // Read data monitor takes the oldest note
   always @(posedge mclk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) check(avs_readdata_o, exp_q.pop_front());
   end
   // Watchdog cuts a hang short
   initial begin
      repeat (5000) @(posedge mclk_i);
      failures++;
      final_report();
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      int r;
      r = $urandom(98198);
      foreach (w[i]) w[i] = 8'($urandom);
      w[0][0] = 1'b0; // Release stays disabled at first
      repeat (20) @(posedge mclk_i);
      srst_i <= 1'b0;
      bus_addr <= 24'($urandom);
      bus_data <= 16'($urandom);
      m_addr <= 24'($urandom);
      for (int i = 0; i < 6; i++) rd(3'(i), (i == 0 || i == 5) ? 8'h00 : 8'hFF);
      rd(3'h6, 8'h04);
      check(32'(u_bma_ext_if.addr[19:0]), 32'(bus_addr[19:0]));
      check(32'(m_data), 32'(bus_data));
      // Staged settings wait for a cycle boundary
      boundary <= 1'b0;
      for (int i = 0; i < 6; i++) acc(1'b1, 3'(i), w[i]);
      acc(1'b1, 3'h7, 8'h5A);
      acc(1'b1, 3'h6, 8'h00);
      repeat (2) @(posedge mclk_i);
      check(32'(bus_width), 32'h0000_00FF);
      check(32'(addr_hi), 32'(w[0][7:4]));
      check(32'(u_bma_ext_if.chip_select_oe), 32'(w[5]));
      boundary <= 1'b1;
      repeat (2) @(posedge mclk_i);
      check({bus_width, acc_state, wait_ctl}, {w[1], w[2], w[3], w[4]});
      for (int i = 0; i < 6; i++) rd(3'(i), w[i]);
      rd(3'h7, 8'h00);
      rd(3'h6, 8'h04);
      // External request ignored until enabled, then granted
      want <= 1'b1;
      repeat (10) @(posedge mclk_i);
      rd(3'h6, 8'h04);
      acc(1'b1, 3'h0, {w[0][7:4], 4'h1});
      repeat (8) @(posedge mclk_i);
      rd(3'h6, 8'h03);
      check(32'({grants, m_granted}), 32'h0000_0011);
      check(32'(u_bma_ext_if.addr), 32'(m_addr));
      want <= 1'b0;
      repeat (6) @(posedge mclk_i);
      rd(3'h6, 8'h04);
      // Priority and release points
      boundary <= 1'b0;
      dma_req <= 1'b1;
      ref_req <= 1'b1;
      repeat (6) @(posedge mclk_i);
      rd(3'h6, 8'h04);
      boundary <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rd(3'h6, 8'h06);
      check(32'({grants, m_granted}), 32'h0000_0008);
      ref_req <= 1'b0;
      ref_done <= 1'b1;
      @(posedge mclk_i);
      ref_done <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rd(3'h6, 8'h05);
      want <= 1'b1;
      repeat (8) @(posedge mclk_i);
      rd(3'h6, 8'h05);
      check(32'({grants, m_granted}), 32'h0000_0004);
      dma_done <= 1'b1;
      @(posedge mclk_i);
      dma_done <= 1'b0;
      repeat (6) @(posedge mclk_i);
      rd(3'h6, 8'h03);
      want <= 1'b0;
      repeat (6) @(posedge mclk_i);
      rd(3'h6, 8'h05);
      dma_req <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rd(3'h6, 8'h04);
      // Internal work hands over at once
      boundary <= 1'b0;
      internal <= 1'b1;
      ref_req <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rd(3'h6, 8'h06);
      ref_req <= 1'b0;
      internal <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rd(3'h6, 8'h04);
      check(32'({grants, m_granted}), 32'h0000_0002);
      // Release enable cleared again before any standby entry
      acc(1'b1, 3'h0, 8'h00);
      rd(3'h0, 8'h00);
      final_report();
   end
endmodule : bus_master_arbiter_with_release_tb
`default_nettype wire
